/* File: logic/stc_pkg.sv */
`default_nettype none
package stc_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int unsigned CMP_COUNT = 16;
  localparam int unsigned PARAM_W = 14;
  localparam int unsigned ANALOG_W = 10;
  localparam int unsigned ANALOG_CH = 4;
  localparam int unsigned RELAY_W = 16;
  localparam int unsigned RELAY_COUNT = 16;
  localparam logic [13:0] PARAM_MAX = 14'h270f;  // 9999
  localparam logic [15:0] VIEW_WRAP = 16'h2710;  // 10000

  // ------------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_GAIN1 = 5'h04;
  localparam logic [4:0] REG_GAIN2 = 5'h08;
  localparam logic [4:0] REG_OFFSET = 5'h0c;
  localparam logic [4:0] REG_HYST = 5'h10;
  localparam logic [4:0] REG_SETP = 5'h14;
  localparam logic [4:0] REG_VIEW1 = 5'h18;
  localparam logic [4:0] REG_VIEW2 = 5'h1c;
  localparam logic [11:0] REG_CONTACTS = 12'h200;
  localparam logic [11:0] REG_STATUS = 12'h204;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [13:0] PARAM_RST = 14'h0000;
  localparam logic [16:0] CTRL_RST = 17'h00000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_less,
    mode_less_equal,
    mode_equal,
    mode_greater_equal,
    mode_greater
  } stc_mode_e;

  typedef enum logic [1:0] {
    src_analog,
    src_setpoint,
    src_timer,
    src_counter
  } stc_src_e;

  // control word, bit 0 upward: mode, src1, sel1, src2, sel2, defs
  typedef struct packed {
    logic gain2_def;
    logic gain1_def;
    logic [3:0] sel2;
    stc_src_e src2;
    logic [3:0] sel1;
    stc_src_e src1;
    stc_mode_e mode;
  } stc_cfg_s;

endpackage
`default_nettype wire

/* File: logic/stc_operand_sel.sv */
`timescale 1ns/100ps
`default_nettype none
module stc_operand_sel (
  input wire stc_pkg::stc_src_e src, // operand source
  input wire logic [3:0] sel, // channel or relay number
  input wire logic [13:0] setpoint, // constant setpoint
  input wire logic [39:0] analog_value, // analog samples
  input wire logic [255:0] timer_value, // timing relay values
  input wire logic [255:0] counter_value, // counter relay values
  output logic signed [31:0] raw, // operand, signed 32-bit
  output logic [13:0] disp // operand as shown in the view
);

  logic [15:0] val;
  logic [15:0] wrapped;

  // ------------------------------------------------------------------
  // source pick
  // ------------------------------------------------------------------
  always_comb begin
    case (src)
      stc_pkg::src_analog: val = {6'h00,
        analog_value[32'(sel[1:0]) * 10 +: 10]};
      stc_pkg::src_setpoint: val = {2'h0, setpoint};
      stc_pkg::src_timer: val = timer_value[32'(sel) * 16 +: 16];
      stc_pkg::src_counter: val = counter_value[32'(sel) * 16 +: 16];
      default: val = 16'h0000;
    endcase
  end

  // view wraps values above 9999
  always_comb begin
    wrapped = val % stc_pkg::VIEW_WRAP;
    disp = wrapped[13:0];
    raw = {16'h0000, val};
  end

endmodule
`default_nettype wire

/* File: logic/stc_cmp_eval.sv */
`timescale 1ns/100ps
`default_nettype none
module stc_cmp_eval (
  input wire stc_pkg::stc_mode_e mode, // comparison mode
  input wire logic signed [31:0] raw1, // first operand raw
  input wire logic signed [31:0] raw2, // second operand raw
  input wire logic [13:0] gain1, // first_gain
  input wire logic [13:0] gain2, // second_gain
  input wire logic gain1_def, // first_gain defined
  input wire logic gain2_def, // second_gain defined
  input wire logic [13:0] offset, // operand_offset
  input wire logic [13:0] hyst, // hysteresis_band
  input wire logic prev, // current contact state
  output logic next // contact state after evaluation
);

  logic signed [31:0] v1;
  logic signed [31:0] v2;
  logic signed [31:0] hi;
  logic signed [31:0] lo;

  // ------------------------------------------------------------------
  // scaling and thresholds, all signed 32-bit
  // ------------------------------------------------------------------
  always_comb begin
    v1 = gain1_def ? raw1 * $signed({18'h00000, gain1}) : raw1;
    v1 = v1 + $signed({18'h00000, offset});
    v2 = gain2_def ? raw2 * $signed({18'h00000, gain2}) : raw2;
    hi = v2 + $signed({18'h00000, hyst});
    lo = v2 - $signed({18'h00000, hyst});
  end

  // switching, holding between thresholds
  always_comb begin
    next = prev;
    case (mode)
      stc_pkg::mode_less: begin
        if (v1 < v2) next = 1'b1;
        else if (v1 > hi) next = 1'b0;
      end
      stc_pkg::mode_less_equal: begin
        if (v1 <= v2) next = 1'b1;
        else if (v1 > hi) next = 1'b0;
      end
      stc_pkg::mode_equal: begin
        if (v1 == v2) next = 1'b1;
        else if (v1 > hi || v1 < lo) next = 1'b0;
      end
      stc_pkg::mode_greater_equal: begin
        if (v1 >= v2) next = 1'b1;
        else if (v1 < lo) next = 1'b0;
      end
      stc_pkg::mode_greater: begin
        if (v1 > v2) next = 1'b1;
        else if (v1 < lo) next = 1'b0;
      end
      default: next = prev;
    endcase
  end

endmodule
`default_nettype wire

/* File: logic/stc_comparator_top.sv */
// Functional notes
// - first operand: analog, timer or counter value (the code also accepts src_setpoint for src1)
// - first operand multiplied by first gain
// - second operand multiplied by second gain
// - offset added to first operand
// - one hysteresis forms upper and lower threshold
// - all arithmetic signed 32-bit, never overflows
// - undefined gain skips the multiplication
// - view shows values above 9999 modulo 10000
// - analog sample is unsigned 10-bit code
// - equality switches only in equal and or-equal modes
// - less: on below setpoint, off above plus hysteresis
// - equal: on at setpoint, off outside band
// - greater-equal: on at setpoint, off below band
// - greater: on above setpoint, off below band
// - sixteen independent comparator instances
// - exactly five modes per instance
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module stc_comparator_top #(
  parameter int unsigned NUM_CMP = stc_pkg::CMP_COUNT
) (
  input wire logic sys_clk, // system clock, 20 MHz
  input wire logic rst, // async reset, active high
  input wire logic [11:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // high until answered
  input wire logic scan_start, // one-cycle program scan pulse
  input wire logic [39:0] analog_value, // four 10-bit samples
  input wire logic [255:0] timing_relay_value, // 16 x 16-bit
  input wire logic [255:0] counter_relay_value, // 16 x 16-bit
  output logic [15:0] contact_out, // comparator contacts
  output logic scan_busy // sweep in progress
);

  localparam int unsigned IDX_W = 4;

  typedef enum logic {st_idle, st_eval} stc_scan_e;

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  stc_pkg::stc_cfg_s cfg_q [NUM_CMP];
  logic [13:0] gain1_q [NUM_CMP];
  logic [13:0] gain2_q [NUM_CMP];
  logic [13:0] offset_q [NUM_CMP];
  logic [13:0] hyst_q [NUM_CMP];
  logic [13:0] setp_q [NUM_CMP];
  logic [13:0] view1_q [NUM_CMP];
  logic [13:0] view2_q [NUM_CMP];
  logic [15:0] contact_q;
  logic [15:0] scan_count_q;
  stc_scan_e scan_q;
  logic [IDX_W-1:0] idx_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic take;
  logic wr_go;
  logic eval_go;

  stc_pkg::stc_cfg_s cur_cfg;
  logic signed [31:0] raw1;
  logic signed [31:0] raw2;
  logic [13:0] disp1;
  logic [13:0] disp2;
  logic next_state;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // instance register hit
  function automatic logic inst_hit(input logic [11:0] a,
                                    input int unsigned n,
                                    input logic [4:0] off);
    inst_hit = (a[11:9] == 3'h0) && (32'(a[8:5]) == n) &&
               (a[4:0] == off);
  endfunction

  // byte-lane merge then clamp to the parameter range
  function automatic logic [13:0] param_wr(input logic [13:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {18'h00000, old};
    for (int b = 0; b < 4; b++) begin
      if (be[b]) m[b*8 +: 8] = wd[b*8 +: 8];
    end
    if (m > {18'h00000, stc_pkg::PARAM_MAX}) param_wr = stc_pkg::PARAM_MAX;
    else param_wr = m[13:0];
  endfunction

  // ------------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------------
  // request taken on the first edge it is seen, answered next cycle
  assign take = (avs_read | avs_write) & wait_q;
  assign wr_go = avs_write & wait_q;

  // waitrequest drops for one cycle per request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~take;
    end
  end

  // read data captured when the request is taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else if (take && avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (avs_address == stc_pkg::REG_CONTACTS) begin
      rdata_d = {16'h0000, contact_q};
    end else if (avs_address == stc_pkg::REG_STATUS) begin
      rdata_d = {15'h0000, scan_q == st_eval, scan_count_q};
    end else begin
      for (int n = 0; n < NUM_CMP; n++) begin
        if (inst_hit(avs_address, n, stc_pkg::REG_CTRL))
          rdata_d = {15'h0000, cfg_q[n]};
        if (inst_hit(avs_address, n, stc_pkg::REG_GAIN1))
          rdata_d = {18'h00000, gain1_q[n]};
        if (inst_hit(avs_address, n, stc_pkg::REG_GAIN2))
          rdata_d = {18'h00000, gain2_q[n]};
        if (inst_hit(avs_address, n, stc_pkg::REG_OFFSET))
          rdata_d = {18'h00000, offset_q[n]};
        if (inst_hit(avs_address, n, stc_pkg::REG_HYST))
          rdata_d = {18'h00000, hyst_q[n]};
        if (inst_hit(avs_address, n, stc_pkg::REG_SETP))
          rdata_d = {18'h00000, setp_q[n]};
        if (inst_hit(avs_address, n, stc_pkg::REG_VIEW1))
          rdata_d = {18'h00000, view1_q[n]};
        if (inst_hit(avs_address, n, stc_pkg::REG_VIEW2))
          rdata_d = {18'h00000, view2_q[n]};
      end
    end
  end

  // ------------------------------------------------------------------
  // per-instance parameter registers
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_inst
      // control word, written only as a whole low half
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cfg_q[g] <= stc_pkg::stc_cfg_s'(stc_pkg::CTRL_RST);
        end else if (wr_go && inst_hit(avs_address, g, stc_pkg::REG_CTRL)
                     && avs_byteenable[1:0] == 2'h3) begin
          // modes beyond the five fall back to less
          cfg_q[g] <= stc_pkg::stc_cfg_s'({avs_writedata[16:3],
            (avs_writedata[2:0] > 3'h4) ? 3'h0 : avs_writedata[2:0]});
        end
      end

      // scaling parameters, clamped to 0..9999
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          gain1_q[g] <= stc_pkg::PARAM_RST;
          gain2_q[g] <= stc_pkg::PARAM_RST;
          offset_q[g] <= stc_pkg::PARAM_RST;
        end else if (wr_go) begin
          if (inst_hit(avs_address, g, stc_pkg::REG_GAIN1))
            gain1_q[g] <= param_wr(gain1_q[g], avs_writedata,
                                   avs_byteenable);
          if (inst_hit(avs_address, g, stc_pkg::REG_GAIN2))
            gain2_q[g] <= param_wr(gain2_q[g], avs_writedata,
                                   avs_byteenable);
          if (inst_hit(avs_address, g, stc_pkg::REG_OFFSET))
            offset_q[g] <= param_wr(offset_q[g], avs_writedata,
                                    avs_byteenable);
        end
      end

      // hysteresis and setpoint
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          hyst_q[g] <= stc_pkg::PARAM_RST;
          setp_q[g] <= stc_pkg::PARAM_RST;
        end else if (wr_go) begin
          if (inst_hit(avs_address, g, stc_pkg::REG_HYST))
            hyst_q[g] <= param_wr(hyst_q[g], avs_writedata,
                                  avs_byteenable);
          if (inst_hit(avs_address, g, stc_pkg::REG_SETP))
            setp_q[g] <= param_wr(setp_q[g], avs_writedata,
                                  avs_byteenable);
        end
      end

      // displayed operand values, refreshed when this one is evaluated
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          view1_q[g] <= stc_pkg::PARAM_RST;
          view2_q[g] <= stc_pkg::PARAM_RST;
        end else if (eval_go && 32'(idx_q) == g) begin
          view1_q[g] <= disp1;
          view2_q[g] <= disp2;
        end
      end

      // contact of this instance
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          contact_q[g] <= 1'b0;
        end else if (eval_go && 32'(idx_q) == g) begin
          contact_q[g] <= next_state;
        end
      end
    end
    for (g = NUM_CMP; g < 16; g++) begin : g_unused
      assign contact_q[g] = 1'b0;
    end
  endgenerate

  // ------------------------------------------------------------------
  // scan sequencer
  // ------------------------------------------------------------------
  assign eval_go = (scan_q == st_eval);

  // one sweep over all instances per scan pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scan_q <= st_idle;
      idx_q <= '0;
    end else begin
      case (scan_q)
        st_idle: begin
          idx_q <= '0;
          if (scan_start) scan_q <= st_eval;
        end
        st_eval: begin
          idx_q <= idx_q + 1'b1;
          if (32'(idx_q) == NUM_CMP - 1) scan_q <= st_idle;
        end
        default: scan_q <= st_idle;
      endcase
    end
  end

  // completed sweeps
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scan_count_q <= 16'h0000;
    end else if (eval_go && 32'(idx_q) == NUM_CMP - 1) begin
      scan_count_q <= scan_count_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // shared datapath for the instance under evaluation
  // ------------------------------------------------------------------
  assign cur_cfg = cfg_q[idx_q];

  stc_operand_sel u_sel1 (
    .src(cur_cfg.src1),
    .sel(cur_cfg.sel1),
    .setpoint(setp_q[idx_q]),
    .analog_value(analog_value),
    .timer_value(timing_relay_value),
    .counter_value(counter_relay_value),
    .raw(raw1),
    .disp(disp1)
  );

  stc_operand_sel u_sel2 (
    .src(cur_cfg.src2),
    .sel(cur_cfg.sel2),
    .setpoint(setp_q[idx_q]),
    .analog_value(analog_value),
    .timer_value(timing_relay_value),
    .counter_value(counter_relay_value),
    .raw(raw2),
    .disp(disp2)
  );

  stc_cmp_eval u_eval (
    .mode(cur_cfg.mode),
    .raw1(raw1),
    .raw2(raw2),
    .gain1(gain1_q[idx_q]),
    .gain2(gain2_q[idx_q]),
    .gain1_def(cur_cfg.gain1_def),
    .gain2_def(cur_cfg.gain2_def),
    .offset(offset_q[idx_q]),
    .hyst(hyst_q[idx_q]),
    .prev(contact_q[idx_q]),
    .next(next_state)
  );

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign contact_out = contact_q;
  assign scan_busy = (scan_q == st_eval);

endmodule
`default_nettype wire

/* File: sim/stc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module stc_checker (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset
  input wire logic [11:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // bus stall
  input wire logic scan_start, // sweep pulse
  input wire logic [15:0] contact_out, // contacts
  input wire logic scan_busy // sweep in progress
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // counts consecutive busy cycles of a sweep
  logic [4:0] run_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      run_q <= 5'h00;
    else
      run_q <= scan_busy ? run_q + 5'h01 : 5'h00;
  end

  // ------------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------------
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd(logic [11:0] a);
    avs_read && avs_waitrequest && avs_address == a;
  endsequence

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  a_bus_answer: assert property (s_taken |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_bus_quiet: assert property (
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_sweep_start: assert property (
    scan_start && !scan_busy |=> scan_busy)
    else $error("sweep did not start");
  a_sweep_len: assert property ($fell(scan_busy) |-> run_q == 5'h10)
    else $error("sweep length wrong");
  a_sweep_bound: assert property (run_q <= 5'h10)
    else $error("sweep too long");
  a_contact_scan: assert property (
    $changed(contact_out) |-> $past(scan_busy))
    else $error("contact changed outside sweep");
  a_gap_zero: assert property (
    s_rd(12'h208) |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_contact_read: assert property (s_rd(stc_pkg::REG_CONTACTS) |=>
    avs_readdata == {16'h0000, $past(contact_out)})
    else $error("contact word mismatch");
  a_status_busy: assert property (s_rd(stc_pkg::REG_STATUS) |=>
    avs_readdata[16] == $past(scan_busy))
    else $error("status busy mismatch");
endmodule

bind stc_comparator_top stc_checker stc_checker_inst (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .scan_start(scan_start), .contact_out(contact_out),
  .scan_busy(scan_busy));
`default_nettype wire

/* File: sim/stc_comparator_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module stc_comparator_top_tb;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic scan_start, scan_busy;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [39:0] analog_value;
  logic [255:0] timing_relay_value, counter_relay_value;
  logic [15:0] contact_out, exp_c;
  logic [43:0] note_q[$];
  logic [43:0] nt;
  int error_cnt, checks, seed, sweeps;
  int g1[16], g2[16], ofs[16], hys[16], sp[16];
  int walk[10] = '{100, 125, 126, 100, 75, 74, 99, 101, 126, 100};
  stc_pkg::stc_cfg_s cfg[16];

  stc_comparator_top stc_comparator_top_inst (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scan_start(scan_start), .analog_value(analog_value),
    .timing_relay_value(timing_relay_value),
    .counter_relay_value(counter_relay_value),
    .contact_out(contact_out), .scan_busy(scan_busy));

  // clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------------
  // bus and sweep helpers
  // ------------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [11:0] ad(input int i, input logic [4:0] o);
    return {i[6:0], o};
  endfunction

  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest && n < 50);
    if (avs_waitrequest) begin
      error_cnt++;
      $display("unexpected waitrequest: expected 0 seen 1");
      conclude();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    note_q.push_back({a, e});
    bus(a, 1'b0, 32'h00000000);
  endtask

  task automatic put(input int i);
    bus(ad(i, stc_pkg::REG_CTRL), 1'b1, {15'h0000, cfg[i]});
    bus(ad(i, stc_pkg::REG_GAIN1), 1'b1, g1[i]);
    bus(ad(i, stc_pkg::REG_GAIN2), 1'b1, g2[i]);
    bus(ad(i, stc_pkg::REG_OFFSET), 1'b1, ofs[i]);
    bus(ad(i, stc_pkg::REG_HYST), 1'b1, hys[i]);
    bus(ad(i, stc_pkg::REG_SETP), 1'b1, sp[i]);
  endtask

  function automatic longint opv(stc_pkg::stc_src_e s, logic [3:0] k,
                                 int i);
    case (s)
      stc_pkg::src_analog: return analog_value[10*k[1:0] +: 10];
      stc_pkg::src_setpoint: return sp[i];
      stc_pkg::src_timer: return timing_relay_value[16*k +: 16];
      default: return counter_relay_value[16*k +: 16];
    endcase
  endfunction

  // reference contact update for all instances, holds inside the band
  task automatic model;
    longint v1, v2, hi, lo;
    logic sw_on, sw_off;
    for (int i = 0; i < 16; i++) begin
      v1 = opv(cfg[i].src1, cfg[i].sel1, i);
      v2 = opv(cfg[i].src2, cfg[i].sel2, i);
      if (cfg[i].gain1_def)
        v1 = v1 * g1[i];
      v1 = v1 + ofs[i];
      if (cfg[i].gain2_def)
        v2 = v2 * g2[i];
      hi = v2 + hys[i];
      lo = v2 - hys[i];
      case (cfg[i].mode)
        stc_pkg::mode_less: {sw_on, sw_off} = {v1 < v2, v1 > hi};
        stc_pkg::mode_less_equal: {sw_on, sw_off} = {v1 <= v2, v1 > hi};
        stc_pkg::mode_equal:
          {sw_on, sw_off} = {v1 == v2, v1 > hi || v1 < lo};
        stc_pkg::mode_greater_equal: {sw_on, sw_off} = {v1 >= v2, v1 < lo};
        default: {sw_on, sw_off} = {v1 > v2, v1 < lo};
      endcase
      exp_c[i] = sw_on ? 1'b1 : (sw_off ? 1'b0 : exp_c[i]);
    end
  endtask

  task automatic sweep;
    int n;
    @(posedge sys_clk);
    scan_start <= 1'b1;
    @(posedge sys_clk);
    scan_start <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (scan_busy && n < 40);
    if (scan_busy) begin
      error_cnt++;
      $display("unexpected scan_busy: expected 0 seen 1");
      conclude();
    end
    sweeps++;
    model();
    rd(stc_pkg::REG_CONTACTS, {16'h0000, exp_c});
  endtask

  // compares each read answer with the oldest note
  always @(posedge sys_clk) begin
    if (!rst && avs_read && !avs_waitrequest) begin
      checks++;
      nt = note_q.size() > 0 ? note_q.pop_front() : 44'h0;
      if (avs_readdata !== nt[31:0]) begin
        error_cnt++;
        $display("unexpected readdata at %h: expected %h seen %h",
                 nt[43:32], nt[31:0], avs_readdata);
      end
      if (nt[43:32] == stc_pkg::REG_CONTACTS) begin
        checks++;
        if (contact_out !== nt[15:0]) begin
          error_cnt++;
          $display("unexpected contact_out: expected %h seen %h",
                   nt[15:0], contact_out);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = 68;
    rst = 1'b1;
    {avs_read, avs_write, scan_start} = 3'h0;
    avs_address = 12'h000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    analog_value = 40'h0000000000;
    timing_relay_value = '0;
    counter_relay_value = '0;
    {error_cnt, checks, sweeps, exp_c} = '0;
    foreach (cfg[i])
      cfg[i] = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ad(0, stc_pkg::REG_CTRL), 32'h00000000);
    rd(ad(3, stc_pkg::REG_HYST), 32'h00000000);
    rd(stc_pkg::REG_STATUS, 32'h00000000);
    rd(12'h208, 32'h00000000);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      cfg[i].mode = stc_pkg::stc_mode_e'(i);
      cfg[i].src2 = stc_pkg::src_setpoint;
      sp[i] = 100;
      hys[i] = 25;
      put(i);
      rd(ad(i, stc_pkg::REG_CTRL), {15'h0000, cfg[i]});
    end
    bus(ad(6, stc_pkg::REG_CTRL), 1'b1, 32'h00000007);
    rd(ad(6, stc_pkg::REG_CTRL), 32'h00000000);
    avs_byteenable <= 4'h1;
    bus(ad(6, stc_pkg::REG_CTRL), 1'b1, 32'h00000002);
    bus(ad(6, stc_pkg::REG_GAIN2), 1'b1, 32'h0000ff34);
    avs_byteenable <= 4'hf;
    rd(ad(6, stc_pkg::REG_CTRL), 32'h00000000);
    rd(ad(6, stc_pkg::REG_GAIN2), 32'h00000034);
    bus(ad(7, stc_pkg::REG_GAIN1), 1'b1, 32'h00003a98);
    rd(ad(7, stc_pkg::REG_GAIN1), 32'h0000270f);
    $display("test config done");
    foreach (walk[j]) begin
      analog_value[9:0] <= walk[j][9:0];
      sweep();
    end
    $display("test modes done");
    cfg[5].mode = stc_pkg::mode_greater_equal;
    cfg[5].src1 = stc_pkg::src_counter;
    cfg[5].sel1 = 4'h3;
    cfg[5].src2 = stc_pkg::src_timer;
    cfg[5].sel2 = 4'h2;
    {cfg[5].gain1_def, cfg[5].gain2_def} = 2'h3;
    {g1[5], g2[5], ofs[5]} = {32'd9999, 32'd9999, 32'd9999};
    put(5);
    counter_relay_value[63:48] <= 16'h270f;
    timing_relay_value[47:32] <= 16'h2710;
    sweep();
    rd(ad(5, stc_pkg::REG_VIEW1), 32'h0000270f);
    rd(ad(5, stc_pkg::REG_VIEW2), 32'h00000000);
    cfg[5].gain1_def = 1'b0;
    put(5);
    counter_relay_value[63:48] <= 16'h27f9;
    sweep();
    rd(ad(5, stc_pkg::REG_VIEW1), 32'h000000e9);
    $display("test scaling done");
    cfg[8].sel1 = 4'h2;
    cfg[8].src2 = stc_pkg::src_setpoint;
    sp[8] = 500;
    put(8);
    repeat (20) begin
      analog_value <= {30'($random(seed)), 10'(70 + {$random(seed)} % 60)};
      counter_relay_value[63:48] <= 16'($random(seed));
      timing_relay_value[47:32] <= 16'($random(seed));
      sweep();
    end
    rd(stc_pkg::REG_STATUS, {16'h0000, sweeps[15:0]});
    $display("test random done");
    conclude();
  end
endmodule
`default_nettype wire
